/* hw/cwe_consts.svh */
// Constants of the socket window enable and I/O window control block.
// Assumes a 100 MHz clk; included by the package users of the cwe block.
`ifndef CWE_CONSTS_SVH
`define CWE_CONSTS_SVH

`define CWE_IDX_WIN_EN   8'h06
`define CWE_IDX_IO_CTL   8'h07
`define CWE_IDX_SOCK_BIT 6
`define CWE_IDX_SOCK1    8'h40
`define CWE_MAP_WIN_EN   12'h806
`define CWE_MAP_IO_CTL   12'h807
`define CWE_REG_RESET    8'h00
`define CWE_EN_WMASK     8'hDF
`define CWE_EN_IO1       7
`define CWE_EN_IO0       6
`define CWE_EN_RSVD      5
`define CWE_MEM_WINS     3'h5
`define CWE_IO_FIXED     0
`define CWE_IO_AUTO      1
`define CWE_IO_SHORT     2
`define CWE_IO_STRETCH   3
`define CWE_CLK_NS       10
`define CWE_ISA_CLK_NS   125
`define CWE_ISA_CLK_CYC  ((`CWE_ISA_CLK_NS + `CWE_CLK_NS - 1) / `CWE_CLK_NS)
`define CWE_STD8_ISA     4'h6
`define CWE_STD16_ISA    4'h3
`define CWE_SHORT8_ISA   4'h3
`define CWE_WAIT_ISA     4'h1
`define CWE_TMR_LAST     8'h01

`endif

/* hw/cwe_cycle_timer.sv */
// Counts out the length of one card I/O cycle in host clocks.
// Assumes start only while not busy and len of at least one.
`timescale 1ns/1ps
`include "cwe_consts.svh"

module cwe_cycle_timer
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       ce,
	// Cycle control
	input  wire logic       start,
	input  wire logic [7:0] len,
	output logic            busy,
	output logic            done
);
	import cwe_pkg::*;

	cwe_tmr_s st_ff;
	cwe_tmr_s nxt_st;

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		case (st_ff.phase)
			TMR_IDLE:
			begin
				if (start)
				begin
					nxt_st.phase = TMR_RUN;
					nxt_st.cnt = len;
				end
			end
			TMR_RUN:
			begin
				if (st_ff.cnt == `CWE_TMR_LAST)
				begin
					nxt_st.phase = TMR_IDLE;
					nxt_st.cnt = `CWE_REG_RESET;
					nxt_st.done = 1'b1;
				end
				else
					nxt_st.cnt = st_ff.cnt - `CWE_TMR_LAST;
			end
			default:
				nxt_st = '0;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			st_ff <= '0;
		else if (ce)
			st_ff <= nxt_st;
	end

	assign busy = (st_ff.phase == TMR_RUN);
	assign done = st_ff.done;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_tmrLoad;
		ce && start && !busy |=> busy && st_ff.cnt == $past(len);
	endproperty
	a_tmrLoad: assert property (p_tmrLoad) else $error("timer did not load length");

	property p_tmrEnd;
		ce && busy && st_ff.cnt == `CWE_TMR_LAST |=> !busy && done;
	endproperty
	a_tmrEnd: assert property (p_tmrEnd) else $error("timer did not end cycle");
endmodule

/* hw/cwe_pkg.sv */
// Types shared by the window control block and its cycle timer.
// Assumes nothing beyond a SystemVerilog compiler.
package cwe_pkg;

	typedef enum logic {TMR_IDLE, TMR_RUN} cwe_tmr_e;

	typedef struct packed {
		cwe_tmr_e   phase;
		logic [7:0] cnt;
		logic       done;
	} cwe_tmr_s;

	typedef struct packed {
		logic [1:0][7:0] winEn;
		logic [1:0][7:0] ioCtl;
		logic [1:0]      wideSync1;
		logic [1:0]      wideSync2;
		logic [1:0]      wide;
		logic [7:0]      rdata;
		logic            ack;
	} cwe_main_s;

endpackage

/* hw/cwe_window_ctrl.sv */
// Per-socket window enable and I/O window control registers, two sockets.
// Assumes host cycle requests and register strobes come from logic on clk;
// the card wide indication pins are asynchronous and get synchronised here.
`timescale 1ns/1ps
`include "cwe_consts.svh"

module cwe_window_ctrl
#(
	parameter int ISA_CLK_CYC = `CWE_ISA_CLK_CYC
)
(
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            reset_n,
	input  wire logic            ce,
	// Register port
	input  wire logic            regMapped,
	input  wire logic            regFunc,
	input  wire logic [11:0]     regAddr,
	input  wire logic            regWr,
	input  wire logic            regRd,
	input  wire logic [7:0]      regWdata,
	output logic      [7:0]      regRdata,
	output logic                 regAck,
	// Host cycles, one lane per socket
	input  wire logic [1:0]      cycReq,
	input  wire logic [1:0]      cycIo,
	input  wire logic [1:0][2:0] cycWin,
	output logic      [1:0]      cycClaim,
	output logic      [1:0]      cycBusy,
	output logic      [1:0]      cycDone,
	output logic      [1:0]      cycWide,
	// Window state for the address decoders
	output logic      [1:0]      ioWindow1Open,
	output logic      [1:0]      ioWindow0Open,
	output logic      [1:0][4:0] memWindowOpen,
	// Card pins
	input  wire logic [1:0]      cardIoWideIndication
);
	import cwe_pkg::*;

	cwe_main_s st_ff;
	cwe_main_s nxt_st;

	logic            regSock;
	logic            hitEn;
	logic            hitCtl;
	logic [1:0]      winOpen;
	logic [1:0]      wideSel;
	logic [1:0][3:0] ctlSel;
	logic [1:0][3:0] isaCnt;
	logic [1:0][7:0] ioLen;
	logic [1:0]      tmrStart;
	logic [1:0]      tmrBusy;
	logic [1:0]      tmrDone;

	// Register address decode, index form or socket-mapped form
	always_comb
	begin
		regSock = 1'b0;
		hitEn = 1'b0;
		hitCtl = 1'b0;
		if (regMapped)
		begin
			regSock = regFunc;
			hitEn = (regAddr == `CWE_MAP_WIN_EN);
			hitCtl = (regAddr == `CWE_MAP_IO_CTL);
		end
		else if ((regAddr & ~{4'h0, `CWE_IDX_SOCK1}) <= {4'h0, `CWE_IDX_IO_CTL})
		begin
			regSock = regAddr[`CWE_IDX_SOCK_BIT];
			hitEn = ({4'h0, regAddr[7:0] & ~`CWE_IDX_SOCK1} == {4'h0, `CWE_IDX_WIN_EN});
			hitCtl = ({4'h0, regAddr[7:0] & ~`CWE_IDX_SOCK1} == {4'h0, `CWE_IDX_IO_CTL});
		end
	end

	// Window selection, width and cycle length per socket
	always_comb
	begin
		for (int s = 0; s < 2; s++)
		begin
			ctlSel[s] = cycWin[s][0] ? st_ff.ioCtl[s][7:4] : st_ff.ioCtl[s][3:0];
			if (cycIo[s])
				winOpen[s] = st_ff.winEn[s][cycWin[s][0] ? `CWE_EN_IO1 : `CWE_EN_IO0];
			else
				winOpen[s] = (cycWin[s] < `CWE_MEM_WINS) && st_ff.winEn[s][cycWin[s]];
			if (ctlSel[s][`CWE_IO_AUTO])
				wideSel[s] = st_ff.wideSync2[s];
			else
				wideSel[s] = ctlSel[s][`CWE_IO_FIXED];
			if (wideSel[s])
				isaCnt[s] = `CWE_STD16_ISA
					+ (ctlSel[s][`CWE_IO_STRETCH] ? `CWE_WAIT_ISA : 4'h0);
			else
				isaCnt[s] = ctlSel[s][`CWE_IO_SHORT] ? `CWE_SHORT8_ISA
					: `CWE_STD8_ISA;
			ioLen[s] = 8'(isaCnt[s] * ISA_CLK_CYC);
			cycClaim[s] = ce && cycReq[s] && winOpen[s]
				&& !(cycIo[s] && tmrBusy[s]);
			tmrStart[s] = cycClaim[s] && cycIo[s];
		end
	end

	// Register writes, reads and pin synchronisers
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.ack = regWr || regRd;
		nxt_st.wideSync1 = cardIoWideIndication;
		nxt_st.wideSync2 = st_ff.wideSync1;
		if (regWr && hitEn)
			nxt_st.winEn[regSock] = regWdata & `CWE_EN_WMASK;
		if (regWr && hitCtl)
			nxt_st.ioCtl[regSock] = regWdata;
		if (regRd)
		begin
			if (hitEn)
				nxt_st.rdata = st_ff.winEn[regSock];
			else if (hitCtl)
				nxt_st.rdata = st_ff.ioCtl[regSock];
			else
				nxt_st.rdata = `CWE_REG_RESET;
		end
		for (int s = 0; s < 2; s++)
		begin
			if (tmrStart[s])
				nxt_st.wide[s] = wideSel[s];
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			st_ff <= '0;
		else if (ce)
			st_ff <= nxt_st;
	end

	// Cycle timers, one per socket
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : gTmr
			cwe_cycle_timer uTimer
			(
				.clk     (clk),
				.reset_n (reset_n),
				.ce      (ce),
				.start   (tmrStart[g]),
				.len     (ioLen[g]),
				.busy    (tmrBusy[g]),
				.done    (tmrDone[g])
			);
			assign ioWindow1Open[g] = st_ff.winEn[g][`CWE_EN_IO1];
			assign ioWindow0Open[g] = st_ff.winEn[g][`CWE_EN_IO0];
			assign memWindowOpen[g] = st_ff.winEn[g][4:0];
		end
	endgenerate

	assign regRdata = st_ff.rdata;
	assign regAck = st_ff.ack;
	assign cycBusy = tmrBusy;
	assign cycDone = tmrDone;
	assign cycWide = st_ff.wide;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_wrEn0;
		ce && regWr && !regMapped && regAddr == {4'h0, `CWE_IDX_WIN_EN};
	endsequence

	sequence s_wrEn1;
		ce && regWr && !regMapped && regAddr == {4'h0, `CWE_IDX_WIN_EN | `CWE_IDX_SOCK1};
	endsequence

	property p_io1Write;
		s_wrEn0 |=> st_ff.winEn[0][`CWE_EN_IO1] == $past(regWdata[`CWE_EN_IO1]);
	endproperty
	a_io1Write: assert property (p_io1Write) else $error("io window 1 bit not written");

	property p_io0Write;
		s_wrEn0 |=> ioWindow0Open[0] == $past(regWdata[`CWE_EN_IO0]);
	endproperty
	a_io0Write: assert property (p_io0Write) else $error("io window 0 bit not written");

	property p_rsvdZero;
		ce && regRd && hitEn |=> regAck && !regRdata[`CWE_EN_RSVD]
			&& !st_ff.winEn[0][`CWE_EN_RSVD] && !st_ff.winEn[1][`CWE_EN_RSVD];
	endproperty
	a_rsvdZero: assert property (p_rsvdZero) else $error("reserved enable bit not zero");

	property p_memWrite;
		s_wrEn0 |=> memWindowOpen[0] == $past(regWdata[4:0]);
	endproperty
	a_memWrite: assert property (p_memWrite) else $error("memory window bits not written");

	property p_sock1Index;
		s_wrEn1 |=> st_ff.winEn[1] == ($past(regWdata) & `CWE_EN_WMASK)
			&& st_ff.winEn[0] == $past(st_ff.winEn[0]);
	endproperty
	a_sock1Index: assert property (p_sock1Index) else $error("second socket index misdecoded");

	property p_ctlMapped;
		ce && regWr && regMapped && regFunc && regAddr == `CWE_MAP_IO_CTL
			|=> st_ff.ioCtl[1] == $past(regWdata) && st_ff.ioCtl[0] == $past(st_ff.ioCtl[0]);
	endproperty
	a_ctlMapped: assert property (p_ctlMapped) else $error("mapped control write lost");

	property p_resetCtl;
		$rose(reset_n) |-> st_ff.ioCtl == '0 && st_ff.winEn == '0 && cycClaim == 2'b00;
	endproperty
	a_resetCtl: assert property (p_resetCtl) else $error("registers not zero after reset");

	sequence s_wrCtl0;
		ce && regWr && !regMapped && regAddr == {4'h0, `CWE_IDX_IO_CTL};
	endsequence

	property p_ctlIndex;
		s_wrCtl0 |=> st_ff.ioCtl[0] == $past(regWdata)
			&& st_ff.ioCtl[1] == $past(st_ff.ioCtl[1]);
	endproperty
	a_ctlIndex: assert property (p_ctlIndex) else $error("socket 0 control lost");

	property p_sock1Io;
		s_wrEn1 |=> ioWindow1Open[1] == $past(regWdata[`CWE_EN_IO1])
			&& ioWindow0Open[1] == $past(regWdata[`CWE_EN_IO0]);
	endproperty
	a_sock1Io: assert property (p_sock1Io) else $error("socket 1 io bits lost");

	property p_unmappedRead;
		ce && regRd && !hitEn && !hitCtl |=> regRdata == `CWE_REG_RESET;
	endproperty
	a_unmappedRead: assert property (p_unmappedRead) else $error("stray read not 0");

	property p_ackAny;
		ce && (regWr || regRd) |=> regAck;
	endproperty
	a_ackAny: assert property (p_ackAny) else $error("register access not acked");

	property p_ctlHold;
		!(ce && regWr && hitCtl) |=> $stable(st_ff.ioCtl);
	endproperty
	a_ctlHold: assert property (p_ctlHold) else $error("control changed without write");

	property p_enHold;
		!(ce && regWr && hitEn) |=> $stable(st_ff.winEn);
	endproperty
	a_enHold: assert property (p_enHold) else $error("enables changed without write");

	property p_rdHold;
		!(ce && regRd) |=> $stable(regRdata);
	endproperty
	a_rdHold: assert property (p_rdHold) else $error("read data changed unread");

	generate
		for (g = 0; g < 2; g++)
		begin : gChk
			property p_noClaimIo;
				cycReq[g] && cycIo[g] && !(cycWin[g][0] ? ioWindow1Open[g] : ioWindow0Open[g])
					|-> !cycClaim[g] ##1 !cycBusy[g] || $past(cycBusy[g]);
			endproperty
			a_noClaimIo: assert property (p_noClaimIo) else $error("io claim on shut");

			property p_noClaimMem;
				cycReq[g] && !cycIo[g]
					&& (cycWin[g] >= `CWE_MEM_WINS || !memWindowOpen[g][cycWin[g]])
					|-> !cycClaim[g];
			endproperty
			a_noClaimMem: assert property (p_noClaimMem) else $error("mem claim on shut");

			property p_stretch;
				tmrStart[g] && wideSel[g] && ctlSel[g][`CWE_IO_STRETCH]
					|-> ioLen[g] == 8'((`CWE_STD16_ISA + `CWE_WAIT_ISA) * ISA_CLK_CYC);
			endproperty
			a_stretch: assert property (p_stretch) else $error("wide cycle not stretched");

			property p_shorten;
				tmrStart[g] && !wideSel[g] && ctlSel[g][`CWE_IO_SHORT]
					|-> ioLen[g] == 8'(`CWE_SHORT8_ISA * ISA_CLK_CYC)
					##1 cycBusy[g];
			endproperty
			a_shorten: assert property (p_shorten) else $error("narrow cycle not shortened");

			property p_autoWidth;
				tmrStart[g] && ctlSel[g][`CWE_IO_AUTO] |=> cycWide[g] == $past(st_ff.wideSync2[g]);
			endproperty
			a_autoWidth: assert property (p_autoWidth) else $error("auto width not followed");

			property p_fixedWidth;
				tmrStart[g] && !ctlSel[g][`CWE_IO_AUTO]
					|=> cycWide[g] == $past(ctlSel[g][`CWE_IO_FIXED]);
			endproperty
			a_fixedWidth: assert property (p_fixedWidth) else $error("fixed width not followed");

			property p_wideStd;
				tmrStart[g] && wideSel[g] && !ctlSel[g][`CWE_IO_STRETCH]
					|-> ioLen[g] == 8'(`CWE_STD16_ISA * ISA_CLK_CYC);
			endproperty
			a_wideStd: assert property (p_wideStd) else $error("wide length off");

			property p_narrowStd;
				tmrStart[g] && !wideSel[g] && !ctlSel[g][`CWE_IO_SHORT]
					|-> ioLen[g] == 8'(`CWE_STD8_ISA * ISA_CLK_CYC);
			endproperty
			a_narrowStd: assert property (p_narrowStd) else $error("narrow length off");

			property p_wideHold;
				!tmrStart[g] |=> $stable(cycWide[g]);
			endproperty
			a_wideHold: assert property (p_wideHold) else $error("width changed mid cycle");
		end
	endgenerate
endmodule

/* testbench/cwe_card_model.sv */
// Card in the socket: drives the I/O wide indication pin of each socket.
// Assumes the bench sets wideCmd per socket; the pin lags like a real decode.
`timescale 1ns/1ps

module cwe_card_model
(
	// Bench control
	input  wire logic [1:0] wideCmd,
	// Card pins
	output logic      [1:0] cardIoWideIndication
);
	// Asynchronous to clk, settles a few ns after the command
	assign #3 cardIoWideIndication = wideCmd;
endmodule

/* testbench/cwe_testbench.sv */
// Self-checking bench for the window enable and I/O window control block.
// Assumes cwe_window_ctrl with a short ISA clock and the card model beside it.
`timescale 1ns/1ps

module testbench;
	import cwe_pkg::*;
	localparam int ISA = 2;
	logic            clk = 1'b0;
	logic            reset_n = 1'b0;
	logic            ce = 1'b1;
	logic            regMapped = 1'b0;
	logic            regFunc = 1'b0;
	logic [11:0]     regAddr = 12'h000;
	logic            regWr = 1'b0;
	logic            regRd = 1'b0;
	logic [7:0]      regWdata = 8'h00;
	logic [7:0]      regRdata;
	logic            regAck;
	logic [1:0]      cycReq = 2'h0;
	logic [1:0]      cycIo = 2'h0;
	logic [1:0][2:0] cycWin = '0;
	logic [1:0]      cycClaim, cycBusy, cycDone, cycWide, ioWindow1Open, ioWindow0Open;
	logic [1:0][4:0] memWindowOpen;
	logic [1:0]      cardIoWideIndication;
	logic [1:0]      wideCmd = 2'h0;
	int              n_errors = 0;
	int              checks_done = 0;

	cwe_window_ctrl #(.ISA_CLK_CYC(ISA)) i_cwe_window_ctrl (.clk(clk), .reset_n(reset_n),
		.ce(ce), .regMapped(regMapped), .regFunc(regFunc), .regAddr(regAddr), .regWr(regWr),
		.regRd(regRd), .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck),
		.cycReq(cycReq), .cycIo(cycIo), .cycWin(cycWin), .cycClaim(cycClaim),
		.cycBusy(cycBusy), .cycDone(cycDone), .cycWide(cycWide),
		.ioWindow1Open(ioWindow1Open), .ioWindow0Open(ioWindow0Open),
		.memWindowOpen(memWindowOpen), .cardIoWideIndication(cardIoWideIndication));
	cwe_card_model i_cwe_card_model (.wideCmd(wideCmd),
		.cardIoWideIndication(cardIoWideIndication));

	always #5 clk = ~clk;

	task automatic give_verdict();
		$display("checks_done %0d n_errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// One register strobe, acked one cycle later
	task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d,
		input logic m = 1'b0, input logic f = 1'b0);
		@(negedge clk);
		regWr = w;
		regRd = !w;
		regAddr = a;
		regWdata = d;
		regMapped = m;
		regFunc = f;
		@(negedge clk);
		regWr = 1'b0;
		regRd = 1'b0;
		chk(regAck, 1'b1, "ack");
	endtask

	task automatic rdChk(input logic [11:0] a, input logic [7:0] exp,
		input logic m = 1'b0, input logic f = 1'b0);
		acc(1'b0, a, 8'h00, m, f);
		chk(regRdata, exp, "read");
	endtask

	// Offers a request for 1 ns only, withdrawn before the next clock edge, so never taken
	task automatic probe(input int s, input logic io, input logic [2:0] w, input logic exp);
		@(negedge clk);
		cycReq[s] = 1'b1;
		cycIo[s] = io;
		cycWin[s] = w;
		#1 chk(cycClaim[s], exp, "claim");
		cycReq[s] = 1'b0;
	endtask

	task automatic ioCyc(input int s, input logic w, input logic expWide, input int expLen);
		int n;
		n = 0;
		@(negedge clk);
		cycReq[s] = 1'b1;
		cycIo[s] = 1'b1;
		cycWin[s] = {2'h0, w};
		#1 chk(cycClaim[s], 1'b1, "io claim");
		@(negedge clk);
		#1 chk(cycClaim[s], 1'b0, "claim while busy");
		cycReq[s] = 1'b0;
		while (cycDone[s] !== 1'b1 && n < 300)
		begin
			n += int'(cycBusy[s]);
			@(negedge clk);
		end
		chk(n[7:0], expLen[7:0], "io length");
		chk(cycWide[s], expWide, "io width");
	endtask

	task automatic t_reset();
		for (int s = 0; s < 2; s++)
		begin
			rdChk({4'h0, s[1:0], 6'h06}, 8'h00);
			rdChk({4'h0, s[1:0], 6'h07}, 8'h00);
			for (int j = 0; j < 8; j++)
				probe(s, 1'b0, j[2:0], 1'b0);
			probe(s, 1'b1, 3'h0, 1'b0);
			probe(s, 1'b1, 3'h1, 1'b0);
		end
	endtask

	task automatic t_enable();
		for (int b = 0; b < 8; b++)
		begin
			acc(1'b1, 12'h006, 8'h01 << b);
			rdChk(12'h006, (8'h01 << b) & 8'hDF);
			for (int j = 0; j < 5; j++)
				probe(0, 1'b0, j[2:0], b == j);
			probe(0, 1'b1, 3'h0, b == 6);
			probe(0, 1'b1, 3'h1, b == 7);
		end
		acc(1'b1, 12'h046, 8'hFF);
		rdChk(12'h046, 8'hDF);
		chk({ioWindow1Open, ioWindow0Open}, 8'h0E, "io open");
		chk({3'h0, memWindowOpen[1]}, 8'h1F, "mem open B");
		for (int j = 5; j < 8; j++)
			probe(1, 1'b0, j[2:0], 1'b0);
		acc(1'b1, 12'h806, 8'hC1, 1'b1, 1'b0);
		rdChk(12'h006, 8'hC1);
		acc(1'b1, 12'h807, 8'hA5, 1'b1, 1'b1);
		rdChk(12'h047, 8'hA5);
		rdChk(12'h807, 8'hA5, 1'b1, 1'b1);
		rdChk(12'h010, 8'h00);
	endtask

	task automatic t_io();
		logic [3:0] nib;
		logic       wide;
		for (int w = 0; w < 2; w++)
			for (int k = 0; k < 16; k++)
			begin
				nib = k[3:0];
				wideCmd[0] = k[0] ^ k[2];
				acc(1'b1, 12'h007, w ? {nib, ~nib} : {~nib, nib});
				repeat (4) @(negedge clk);
				wide = nib[1] ? wideCmd[0] : nib[0];
				ioCyc(0, w[0], wide, wide ? (3 + nib[3]) * ISA : (nib[2] ? 3 : 6) * ISA);
			end
		acc(1'b1, 12'h047, 8'h00);
		ioCyc(1, 1'b1, 1'b0, 6 * ISA);
	endtask

	task automatic t_ce();
		@(negedge clk);
		ce = 1'b0;
		cycReq[1] = 1'b1;
		cycIo[1] = 1'b0;
		cycWin[1] = 3'h0;
		#1 chk(cycClaim[1], 1'b0, "claim with ce low");
		cycReq[1] = 1'b0;
		regWr = 1'b1;
		regAddr = 12'h046;
		regWdata = 8'h00;
		@(negedge clk);
		chk(regAck, 1'b0, "ack with ce low");
		regWr = 1'b0;
		ce = 1'b1;
		rdChk(12'h046, 8'hDF);
	endtask

	// Reset in mid run clears both sockets again
	task automatic t_midReset();
		@(negedge clk);
		reset_n = 1'b0;
		@(negedge clk);
		chk({4'h0, ioWindow1Open, ioWindow0Open}, 8'h00, "io open in reset");
		chk({3'h0, memWindowOpen[0]}, 8'h00, "mem open A in reset");
		chk({3'h0, memWindowOpen[1]}, 8'h00, "mem open B in reset");
		reset_n = 1'b1;
		for (int s = 0; s < 2; s++)
		begin
			rdChk({4'h0, s[1:0], 6'h06}, 8'h00);
			rdChk({4'h0, s[1:0], 6'h07}, 8'h00);
			probe(s, 1'b1, 3'h1, 1'b0);
		end
	endtask

	initial
	begin
		#500000;
		n_errors++;
		give_verdict();
	end

	initial
	begin
		repeat (10) @(negedge clk);
		reset_n = 1'b1;
		t_reset();
		t_enable();
		t_io();
		t_ce();
		t_midReset();
		give_verdict();
	end
endmodule
